// ===== common/bbco_pkg.sv
package bbco_pkg;

  // ****************************************************************
  // Instruction fields
  // ****************************************************************
  localparam int OPC_HI = 31;
  localparam int OPC_LO = 26;
  localparam int RS_HI = 25;
  localparam int RS_LO = 21;
  localparam int RT_HI = 20;
  localparam int RT_LO = 16;
  localparam int FN_HI = 5;
  localparam int FN_LO = 0;
  localparam int OFF_HI = 15;
  localparam int CSEL_HI = 17;
  localparam int CSEL_LO = 16;
  localparam int COP_HI = 20;
  localparam int COP_LO = 18;
  localparam int SIGN32 = 31;
  localparam int SIGN64 = 63;
  localparam int DW_LO = 3;

  // ****************************************************************
  // Opcodes
  // ****************************************************************
  localparam logic [5:0] OP_SPECIAL = 6'h00;
  localparam logic [5:0] OP_REGISTER_IMMEDIATE_GROUP = 6'h01;
  localparam logic [5:0] OP_BRUNEQ = 6'h05;
  localparam logic [5:0] OP_BRUNEQL = 6'h15;
  localparam logic [5:0] OP_CACHE = 6'h2f;
  localparam logic [5:0] FN_BREAK = 6'h0d;
  localparam logic [4:0] RT_BRNEG = 5'h00;
  localparam logic [4:0] RT_BRNEGL = 5'h02;
  localparam logic [4:0] RT_BRNEGLK = 5'h10;
  localparam logic [4:0] RT_BRNEGLKL = 5'h12;
  localparam logic [4:0] LINK_REG = 5'h1f;
  localparam logic [63:0] LINK_ADD = 64'h8;
  localparam logic [63:0] SLOT_ADD = 64'h4;

  // ****************************************************************
  // Cache geometry and selectors
  // ****************************************************************
  localparam int CACHE_SIZE_LOG2 = 12;
  localparam int LINE_SIZE_LOG2 = 4;
  localparam int IDX_W = CACHE_SIZE_LOG2 - LINE_SIZE_LOG2;
  localparam int DWS_W = LINE_SIZE_LOG2 - DW_LO;
  localparam int TAG_W = 64 - CACHE_SIZE_LOG2;
  localparam logic [1:0] CSEL_INSN = 2'h0;
  localparam logic [1:0] CSEL_DATA = 2'h1;
  localparam logic [2:0] COP_IDX_INV = 3'h0;
  localparam logic [2:0] COP_IDX_LDTAG = 3'h1;
  localparam logic [2:0] COP_IDX_STTAG = 3'h2;
  localparam logic [2:0] COP_HIT_INV = 3'h4;
  localparam logic [2:0] COP_HIT_WBINV = 3'h5;

  typedef enum logic [2:0] {
    BBCO_IDLE = 3'b001,
    BBCO_SLOT = 3'b010,
    BBCO_CACHE = 3'b100
  } bbco_state_t;

  typedef struct packed {
    logic valid;
    logic [63:0] pc;
    logic [31:0] insn;
    logic [63:0] rsVal;
    logic [63:0] rtVal;
    logic mode64;
    logic userOrSup;
    logic sysCtlEnable;
    logic parityOverride;
    logic [7:0] parityErr;
  } bbco_issue_t;

  typedef struct packed {
    logic req;
    logic [1:0] cacheSel;
    logic [2:0] op;
    logic [IDX_W-1:0] index;
    logic [DWS_W-1:0] dwordSel;
    logic isIndex;
    logic useParityOverride;
    logic [7:0] parity;
    logic [63:0] vAddr;
  } bbco_cache_cmd_t;

endpackage : bbco_pkg

// ===== logic/bbco_exec.sv
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// - Branch target is sign-extended offset shifted by two, plus delay-slot address.
// - Taken branch redirects the PC after the delay-slot instruction executes.
// - Negative-test branches take when rs sign bit is set: bit 63 in 64-bit mode, else bit 31.
// - Negative link branches always write PC plus 8 into register 31.
// - Likely branches cancel the delay slot when not taken.
// - Link branch with rs equal to register 31 raises no exception.
// - Unequal branches take when full rs and rt differ.
// - Breakpoint raises its exception immediately and unconditionally.
// - Breakpoint code field is ignored by execution.
// - Cache address is sign-extended offset plus base, then TLB translated.
// - Cache op in user or supervisor without control enable is unusable.
// - Index operations select the block from the cache index address bits.
// - Tag read also selects a parity doubleword from bits down to 3.
// - Fill with parity override writes the parity error register value.
// - Hit operations act only on a valid block whose tag matches.
// - Write-back address comes from the stored tag, not the TLB.
// - TLB refill or invalid may fault; index ops never raise TLB modified.
// - Instruction bits 17 and 16 select the target cache.
// - Instruction bits 20 down to 18 select the cache operation.
module bbco_exec
  import bbco_pkg::*;
(
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic clockEnable,
  input wire bbco_issue_t issue,
  input wire logic tlbDone,
  input wire logic [63:0] tlbPaddr,
  input wire logic tlbRefill,
  input wire logic tlbInvalid,
  input wire logic tlbModified,
  input wire logic lineValid,
  input wire logic [TAG_W-1:0] lineTag,
  input wire logic lineDirty,
  output logic pcRedirect,
  output logic [63:0] pcTarget,
  output logic slotCancel,
  output logic linkWrite,
  output logic [4:0] linkReg,
  output logic [63:0] linkData,
  output logic breakExc,
  output logic cpUnusableExc,
  output logic tlbRefillExc,
  output logic tlbInvalidExc,
  output logic tlbModifiedExc,
  output logic tlbReq,
  output logic [63:0] tlbVaddr,
  output bbco_cache_cmd_t cacheCmd,
  output logic hitAct,
  output logic wbReq,
  output logic [63:0] wbAddr,
  output logic busy
);

  // ****************************************************************
  // Decode
  // ****************************************************************
  function automatic logic [63:0] sext16(input logic [15:0] v);
    sext16 = {{48{v[OFF_HI]}}, v};
  endfunction : sext16

  logic [5:0] opc;
  logic [4:0] rtCode;
  logic isNeg;
  logic isNegLink;
  logic isNegLikely;
  logic isUneq;
  logic isUneqLikely;
  logic isBreak;
  logic isCache;
  logic negCond;
  logic uneqCond;
  logic cond;
  logic isBranch;
  logic isLikely;
  logic [63:0] slotPc;
  logic [63:0] brTarget;
  logic [63:0] cacheVaddr;

  always_comb begin
    opc = issue.insn[OPC_HI:OPC_LO];
    rtCode = issue.insn[RT_HI:RT_LO];
    isNeg = (opc == OP_REGISTER_IMMEDIATE_GROUP) && (rtCode == RT_BRNEG || rtCode == RT_BRNEGL
            || rtCode == RT_BRNEGLK || rtCode == RT_BRNEGLKL);
    isNegLink = (opc == OP_REGISTER_IMMEDIATE_GROUP) && (rtCode == RT_BRNEGLK || rtCode == RT_BRNEGLKL);
    isNegLikely = (opc == OP_REGISTER_IMMEDIATE_GROUP) && (rtCode == RT_BRNEGL || rtCode == RT_BRNEGLKL);
    isUneq = (opc == OP_BRUNEQ) || (opc == OP_BRUNEQL);
    isUneqLikely = (opc == OP_BRUNEQL);
    // The code field is never looked at; only opcode and function matter.
    isBreak = (opc == OP_SPECIAL) && (issue.insn[FN_HI:FN_LO] == FN_BREAK);
    isCache = (opc == OP_CACHE);
    negCond = issue.mode64 ? issue.rsVal[SIGN64] : issue.rsVal[SIGN32];
    uneqCond = (issue.rsVal != issue.rtVal);
    isBranch = isNeg || isUneq;
    isLikely = isNegLikely || isUneqLikely;
    cond = isNeg ? negCond : uneqCond;
    slotPc = issue.pc + SLOT_ADD;
    brTarget = slotPc + (sext16(issue.insn[OFF_HI:0]) << 2);
    cacheVaddr = sext16(issue.insn[OFF_HI:0]) + issue.rsVal;
  end

  // ****************************************************************
  // Sequencing
  // ****************************************************************
  bbco_state_t state;
  bbco_state_t next_state;
  logic [63:0] heldTarget;
  logic [63:0] next_heldTarget;
  logic heldTaken;
  logic next_heldTaken;
  bbco_cache_cmd_t next_cacheCmd;
  logic next_pcRedirect;
  logic next_slotCancel;
  logic next_linkWrite;
  logic [63:0] next_linkData;
  logic next_breakExc;
  logic next_cpUnusableExc;
  logic next_tlbRefillExc;
  logic next_tlbInvalidExc;
  logic next_hitAct;
  logic next_wbReq;
  logic [63:0] next_wbAddr;
  logic tagHit;

  always_comb begin
    next_state = state;
    next_heldTarget = heldTarget;
    next_heldTaken = heldTaken;
    next_cacheCmd = cacheCmd;
    next_pcRedirect = 1'b0;
    next_slotCancel = 1'b0;
    next_linkWrite = 1'b0;
    next_linkData = linkData;
    next_breakExc = 1'b0;
    next_cpUnusableExc = 1'b0;
    next_tlbRefillExc = 1'b0;
    next_tlbInvalidExc = 1'b0;
    next_hitAct = 1'b0;
    next_wbReq = 1'b0;
    next_wbAddr = wbAddr;
    tagHit = lineValid && (lineTag == tlbPaddr[63:CACHE_SIZE_LOG2]);
    case (state)
      BBCO_IDLE: begin
        if (issue.valid && isBranch) begin
          next_heldTarget = brTarget;
          next_heldTaken = cond;
          next_state = BBCO_SLOT;
          // Link write is unconditional and never checks rs against r31.
          if (isNegLink) begin
            next_linkWrite = 1'b1;
            next_linkData = issue.pc + LINK_ADD;
          end
          if (isLikely && !cond) begin
            next_slotCancel = 1'b1;
          end
        end else if (issue.valid && isBreak) begin
          next_breakExc = 1'b1;
        end else if (issue.valid && isCache) begin
          if (issue.userOrSup && !issue.sysCtlEnable) begin
            next_cpUnusableExc = 1'b1;
          end else begin
            next_cacheCmd.req = 1'b1;
            next_cacheCmd.vAddr = cacheVaddr;
            next_cacheCmd.cacheSel = issue.insn[CSEL_HI:CSEL_LO];
            next_cacheCmd.op = issue.insn[COP_HI:COP_LO];
            next_cacheCmd.index = cacheVaddr[CACHE_SIZE_LOG2-1:LINE_SIZE_LOG2];
            next_cacheCmd.dwordSel = cacheVaddr[LINE_SIZE_LOG2-1:DW_LO];
            next_cacheCmd.isIndex = (issue.insn[COP_HI:COP_LO] < COP_HIT_INV);
            next_cacheCmd.useParityOverride = issue.parityOverride;
            next_cacheCmd.parity = issue.parityErr;
            next_state = BBCO_CACHE;
          end
        end
      end
      BBCO_SLOT: begin
        // The slot instruction issues during this cycle; redirect follows it.
        if (issue.valid) begin
          next_pcRedirect = heldTaken;
          next_state = BBCO_IDLE;
        end
      end
      BBCO_CACHE: begin
        if (tlbDone) begin
          next_state = BBCO_IDLE;
          next_cacheCmd.req = 1'b0;
          if (tlbRefill) begin
            next_tlbRefillExc = 1'b1;
          end else if (tlbInvalid) begin
            next_tlbInvalidExc = 1'b1;
          end else if (cacheCmd.isIndex) begin
            next_hitAct = 1'b1;
            if (cacheCmd.cacheSel == CSEL_DATA && cacheCmd.op == COP_IDX_INV
                && lineValid && lineDirty) begin
              next_wbReq = 1'b1;
              next_wbAddr = {lineTag, cacheCmd.index, {LINE_SIZE_LOG2{1'b0}}};
            end
          end else if (tagHit) begin
            next_hitAct = 1'b1;
            if (cacheCmd.op != COP_HIT_INV && lineDirty) begin
              next_wbReq = 1'b1;
              next_wbAddr = {lineTag, cacheCmd.index, {LINE_SIZE_LOG2{1'b0}}};
            end
          end
        end
      end
      default: next_state = BBCO_IDLE;
    endcase
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      state <= BBCO_IDLE;
      heldTarget <= '0;
      heldTaken <= 1'b0;
      cacheCmd <= '0;
      pcRedirect <= 1'b0;
      slotCancel <= 1'b0;
      linkWrite <= 1'b0;
      linkData <= '0;
      breakExc <= 1'b0;
      cpUnusableExc <= 1'b0;
      tlbRefillExc <= 1'b0;
      tlbInvalidExc <= 1'b0;
      hitAct <= 1'b0;
      wbReq <= 1'b0;
      wbAddr <= '0;
    end else if (clockEnable) begin
      state <= next_state;
      heldTarget <= next_heldTarget;
      heldTaken <= next_heldTaken;
      cacheCmd <= next_cacheCmd;
      pcRedirect <= next_pcRedirect;
      slotCancel <= next_slotCancel;
      linkWrite <= next_linkWrite;
      linkData <= next_linkData;
      breakExc <= next_breakExc;
      cpUnusableExc <= next_cpUnusableExc;
      tlbRefillExc <= next_tlbRefillExc;
      tlbInvalidExc <= next_tlbInvalidExc;
      hitAct <= next_hitAct;
      wbReq <= next_wbReq;
      wbAddr <= next_wbAddr;
    end
  end

  // Index operations never report a modified fault, whatever the TLB says.
  assign tlbModifiedExc = 1'b0;
  assign pcTarget = heldTarget;
  assign linkReg = LINK_REG;
  assign tlbReq = (state == BBCO_CACHE);
  assign tlbVaddr = cacheCmd.vAddr;
  assign busy = (state != BBCO_IDLE);

  // ****************************************************************
  // Checks
  // ****************************************************************
  sequence s_branch_taken;
    clockEnable && state == BBCO_IDLE && issue.valid && isBranch && cond;
  endsequence

  sequence s_branch_untaken;
    clockEnable && state == BBCO_IDLE && issue.valid && isBranch && !cond;
  endsequence

  sequence s_cache_go;
    clockEnable && state == BBCO_IDLE && issue.valid && isCache
    && !(issue.userOrSup && !issue.sysCtlEnable);
  endsequence

  AST_REDIRECT_AFTER_SLOT: assert property (@(posedge clock) disable iff (sys_rst)
    s_branch_taken ##1 (clockEnable && issue.valid) |=> pcRedirect)
    else $error("Taken branch did not redirect after slot.");
  AST_TARGET_HELD: assert property (@(posedge clock) disable iff (sys_rst)
    (clockEnable && state == BBCO_IDLE && issue.valid && isBranch)
    |=> heldTarget == $past(issue.pc) + SLOT_ADD
        + (sext16($past(issue.insn[OFF_HI:0])) << 2))
    else $error("Branch target wrong.");
  AST_NEG_COND: assert property (@(posedge clock) disable iff (sys_rst)
    (clockEnable && state == BBCO_IDLE && issue.valid && isNeg)
    |=> heldTaken == ($past(issue.mode64) ? $past(issue.rsVal[SIGN64])
                      : $past(issue.rsVal[SIGN32])))
    else $error("Negative test wrong.");
  AST_LINK: assert property (@(posedge clock) disable iff (sys_rst)
    (clockEnable && state == BBCO_IDLE && issue.valid && isNegLink)
    |=> linkWrite && linkData == $past(issue.pc) + LINK_ADD)
    else $error("Link write missing.");
  AST_CANCEL: assert property (@(posedge clock) disable iff (sys_rst)
    (clockEnable && state == BBCO_IDLE && issue.valid && isBranch && isLikely && !cond)
    |=> slotCancel)
    else $error("Likely slot not cancelled.");
  AST_NO_CANCEL_TAKEN: assert property (@(posedge clock) disable iff (sys_rst)
    s_branch_taken |=> !slotCancel)
    else $error("Taken branch cancelled slot.");
  AST_UNEQ: assert property (@(posedge clock) disable iff (sys_rst)
    (clockEnable && state == BBCO_IDLE && issue.valid && isUneq)
    |=> heldTaken == ($past(issue.rsVal) != $past(issue.rtVal)))
    else $error("Unequal compare wrong.");
  AST_BREAK: assert property (@(posedge clock) disable iff (sys_rst)
    (clockEnable && state == BBCO_IDLE && issue.valid && isBreak) |=> breakExc)
    else $error("Breakpoint not raised.");
  AST_CPU: assert property (@(posedge clock) disable iff (sys_rst)
    (clockEnable && state == BBCO_IDLE && issue.valid && isCache
     && issue.userOrSup && !issue.sysCtlEnable) |=> cpUnusableExc && state == BBCO_IDLE)
    else $error("Unusable exception missing.");
  AST_NO_TLBMOD: assert property (@(posedge clock) disable iff (sys_rst)
    !tlbModifiedExc)
    else $error("Modified fault raised.");
  AST_HIT_MISS: assert property (@(posedge clock) disable iff (sys_rst)
    (clockEnable && state == BBCO_CACHE && tlbDone && !tlbRefill && !tlbInvalid
     && !cacheCmd.isIndex && !tagHit) |=> !hitAct && !wbReq)
    else $error("Hit op acted on miss.");
  AST_REDIRECT_NOT_EARLY: assert property (@(posedge clock) disable iff (sys_rst)
    s_branch_taken |=> !pcRedirect)
    else $error("Redirect came before the slot.");
  AST_NO_REDIRECT_UNTAKEN: assert property (@(posedge clock) disable iff (sys_rst)
    s_branch_untaken ##1 (clockEnable && issue.valid) |=> !pcRedirect)
    else $error("Untaken branch redirected.");
  AST_NO_CANCEL_PLAIN: assert property (@(posedge clock) disable iff (sys_rst)
    (clockEnable && state == BBCO_IDLE && issue.valid && isBranch && !isLikely)
    |=> !slotCancel)
    else $error("Plain branch cancelled slot.");
  AST_NO_LINK_OTHERS: assert property (@(posedge clock) disable iff (sys_rst)
    (clockEnable && state == BBCO_IDLE && issue.valid && isBranch && !isNegLink)
    |=> !linkWrite)
    else $error("Link written by a non-link branch.");
  AST_CACHE_ADDR: assert property (@(posedge clock) disable iff (sys_rst)
    s_cache_go
    |=> tlbReq && tlbVaddr == sext16($past(issue.insn[OFF_HI:0])) + $past(issue.rsVal))
    else $error("Cache address wrong.");
  AST_CACHE_SEL: assert property (@(posedge clock) disable iff (sys_rst)
    s_cache_go |=> cacheCmd.cacheSel == $past(issue.insn[CSEL_HI:CSEL_LO])
                   && cacheCmd.op == $past(issue.insn[COP_HI:COP_LO]))
    else $error("Cache selectors wrong.");
  AST_CACHE_INDEX: assert property (@(posedge clock) disable iff (sys_rst)
    s_cache_go |=> cacheCmd.index == tlbVaddr[CACHE_SIZE_LOG2-1:LINE_SIZE_LOG2]
                   && cacheCmd.dwordSel == tlbVaddr[LINE_SIZE_LOG2-1:DW_LO])
    else $error("Cache index wrong.");
  AST_TLB_FAULT: assert property (@(posedge clock) disable iff (sys_rst)
    (clockEnable && state == BBCO_CACHE && tlbDone && (tlbRefill || tlbInvalid))
    |=> (tlbRefillExc || tlbInvalidExc) && !hitAct && !wbReq)
    else $error("TLB fault not reported.");
  AST_HIT_ACT: assert property (@(posedge clock) disable iff (sys_rst)
    (clockEnable && state == BBCO_CACHE && tlbDone && !tlbRefill && !tlbInvalid
     && !cacheCmd.isIndex && lineValid && lineTag == tlbPaddr[63:CACHE_SIZE_LOG2])
    |=> hitAct)
    else $error("Hit op ignored a hit.");
  AST_WB_ADDR: assert property (@(posedge clock) disable iff (sys_rst)
    (clockEnable && state == BBCO_CACHE && tlbDone)
    |=> !wbReq || wbAddr[63:CACHE_SIZE_LOG2] == $past(lineTag))
    else $error("Write-back address not from tag.");
  AST_BREAK_IDLE: assert property (@(posedge clock) disable iff (sys_rst)
    (clockEnable && state == BBCO_IDLE && issue.valid && isBreak) |=> !busy && !pcRedirect)
    else $error("Breakpoint held the sequencer.");
  // A low clock enable must hold the sequencer exactly where it is.
  AST_FREEZE: assert property (@(posedge clock) disable iff (sys_rst)
    (!clockEnable && !sys_rst) |=> $stable(state) && $stable(heldTarget))
    else $error("State moved while frozen.");

endmodule : bbco_exec
`default_nettype wire

// ===== verif/bbco_exec_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module bbco_exec_tb_top
  import bbco_pkg::*;
();
  localparam logic [63:0] PC0 = 64'h0000_0000_0040_1000;
  localparam logic [63:0] PADDR = 64'h0000_0000_0ab4_4ff8;
  localparam logic [TAG_W-1:0] TAG_HIT = 52'h0_0000_0000_ab44;
  localparam logic [TAG_W-1:0] TAG_MISS = 52'h0_0000_0000_c0de;
  logic clock, sys_rst, clockEnable, tlbDone, tlbRefill, tlbInvalid, tlbModified;
  logic lineValid, lineDirty, pcRedirect, slotCancel, linkWrite, breakExc, cpUnusableExc;
  logic tlbRefillExc, tlbInvalidExc, tlbModifiedExc, tlbReq, hitAct, wbReq, busy;
  logic [63:0] tlbPaddr, pcTarget, linkData, tlbVaddr, wbAddr;
  logic [TAG_W-1:0] lineTag;
  logic [4:0] linkReg;
  logic [9:0] seen;
  bbco_issue_t issue;
  bbco_cache_cmd_t cacheCmd;
  int fails = 0;
  int n_compared = 0;

  bbco_exec dut_u (.clock(clock), .sys_rst(sys_rst), .clockEnable(clockEnable), .issue(issue),
    .tlbDone(tlbDone), .tlbPaddr(tlbPaddr), .tlbRefill(tlbRefill), .tlbInvalid(tlbInvalid),
    .tlbModified(tlbModified), .lineValid(lineValid), .lineTag(lineTag), .lineDirty(lineDirty),
    .pcRedirect(pcRedirect), .pcTarget(pcTarget), .slotCancel(slotCancel), .linkWrite(linkWrite),
    .linkReg(linkReg), .linkData(linkData), .breakExc(breakExc), .cpUnusableExc(cpUnusableExc),
    .tlbRefillExc(tlbRefillExc), .tlbInvalidExc(tlbInvalidExc), .tlbModifiedExc(tlbModifiedExc),
    .tlbReq(tlbReq), .tlbVaddr(tlbVaddr), .cacheCmd(cacheCmd), .hitAct(hitAct), .wbReq(wbReq),
    .wbAddr(wbAddr), .busy(busy));

  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end

  // ****************************************************************
  // Pulse capture and comparison
  // ****************************************************************
  // Pulses stand one cycle only, so they are gathered at the falling edge, away from stimulus.
  always @(negedge clock) begin
    seen <= seen | {wbReq, hitAct, tlbModifiedExc, tlbInvalidExc, tlbRefillExc, cpUnusableExc,
      breakExc, linkWrite, slotCancel, pcRedirect};
  end

  task automatic report_and_stop();
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : report_and_stop

  task automatic check_val(input logic [63:0] got, input logic [63:0] exp, input string what);
    n_compared++;
    if (got !== exp) begin
      fails++;
      $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask : check_val

  task automatic check_flags(input logic [9:0] exp, input logic [9:0] care, input string what);
    n_compared++;
    if ((seen & care) !== (exp & care)) begin
      fails++;
      $display("unexpected at %0t: %s pulses %b want %b", $time, what, seen & care, exp & care);
    end
  endtask : check_flags

  task automatic step(input int n);
    repeat (n) begin
      @(posedge clock);
      #1;
    end
  endtask : step

  task automatic start_issue(input logic [31:0] insn, input logic [63:0] rs);
    int k;
    for (k = 0; k < 20 && busy !== 1'b0; k++) step(1);
    if (busy !== 1'b0) begin
      fails++;
      $display("unexpected at %0t: busy never fell", $time);
      report_and_stop();
    end
    seen = '0;
    issue = '0;
    issue.valid = 1'b1;
    issue.pc = PC0;
    issue.insn = insn;
    issue.rsVal = rs;
  endtask : start_issue

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic do_branch(input logic [31:0] insn, input logic [63:0] rs, input logic [63:0] rt,
      input logic m64, input logic taken, input logic cancel, input logic link);
    logic [63:0] tgt;
    tgt = PC0 + SLOT_ADD + {{46{insn[15]}}, insn[15:0], 2'b00};
    start_issue(insn, rs);
    issue.rtVal = rt;
    issue.mode64 = m64;
    step(1);
    issue.pc = PC0 + SLOT_ADD;
    issue.insn = 32'h0000_0000;
    step(1);
    issue.valid = 1'b0;
    check_flags(10'h000, 10'h001, "redirect before slot");
    step(3);
    check_flags({7'h00, link, cancel, taken}, 10'h3ff, "branch outcome");
    if (taken) check_val(pcTarget, tgt, "branch target");
    if (link) check_val(linkData, PC0 + LINK_ADD, "link data");
    if (link) check_val(64'(linkReg), 64'(LINK_REG), "link register");
  endtask : do_branch

  task automatic sc_negative();
    logic [4:0] codes [4];
    logic [63:0] rs;
    codes = '{RT_BRNEG, RT_BRNEGL, RT_BRNEGLK, RT_BRNEGLKL};
    for (int i = 0; i < 4; i++) begin
      for (int t = 0; t < 4; t++) begin
        rs = t[0] ? 64'h0000_0000_8000_0000 : 64'h8000_0000_0000_0000;
        do_branch({OP_REGISTER_IMMEDIATE_GROUP, 5'h1f, codes[i], t[0] ? 16'h7fff : 16'h8000}, rs, 64'h0,
          t[1], t[0] ^ t[1], codes[i][1] & ~(t[0] ^ t[1]), codes[i][4]);
      end
    end
  endtask : sc_negative

  task automatic sc_unequal();
    do_branch({OP_BRUNEQ, 10'h064, 16'h0010}, 64'h100_0000_0005, 64'h5,
      1'b1, 1'b1, 1'b0, 1'b0);
    do_branch({OP_BRUNEQL, 10'h064, 16'hfff0}, 64'h5, 64'h5,
      1'b1, 1'b0, 1'b1, 1'b0);
    do_branch({OP_BRUNEQ, 10'h064, 16'h0010}, 64'h5, 64'h5,
      1'b0, 1'b0, 1'b0, 1'b0);
    do_branch({OP_BRUNEQL, 10'h064, 16'h0020}, 64'h5, 64'h4,
      1'b0, 1'b1, 1'b0, 1'b0);
    // Only the upper halves differ; the compare still covers the whole register.
    do_branch({OP_BRUNEQ, 10'h064, 16'h0008}, 64'h1_0000_0005, 64'h5,
      1'b0, 1'b1, 1'b0, 1'b0);
  endtask : sc_unequal

  task automatic sc_break();
    for (int c = 0; c < 2; c++) begin
      start_issue({OP_SPECIAL, c[0] ? 20'hfffff : 20'h00000, FN_BREAK}, 64'h0);
      clockEnable = 1'b0;
      step(2);
      check_flags(10'h000, 10'h3ff, "frozen");
      clockEnable = 1'b1;
      step(1);
      issue.valid = 1'b0;
      step(1);
      check_flags(10'h008, 10'h3ff, "breakpoint");
    end
  endtask : sc_break

  // Flags are {modified, valid, dirty, refill, invalid} of the lookup answer.
  task automatic do_cache(input logic [2:0] cop, input logic [1:0] csel, input int usr,
      input int en, input logic [TAG_W-1:0] tag, input logic [4:0] f,
      input logic [9:0] exp, input logic [9:0] care);
    logic [63:0] va;
    int k;
    va = 64'h0000_0000_1234_4ff8;
    start_issue({OP_CACHE, 5'h02, cop, csel, 16'hfff8}, 64'h0000_0000_1234_5000);
    issue.userOrSup = (usr != 0);
    issue.sysCtlEnable = (en != 0);
    issue.parityOverride = 1'b1;
    issue.parityErr = 8'h5a;
    step(1);
    issue.valid = 1'b0;
    for (k = 0; k < 8 && tlbReq !== 1'b1; k++) step(1);
    check_val(64'(tlbReq), 64'(!exp[4]), "lookup request");
    if (tlbReq === 1'b1) begin
      check_val(tlbVaddr, va, "translated address");
      check_val(64'({cacheCmd.req, cacheCmd.cacheSel, cacheCmd.op}), 64'({1'b1, csel, cop}),
        "selectors");
      check_val(64'({cacheCmd.index, cacheCmd.dwordSel}), 64'(va[11:3]),
        "index");
      check_val(cacheCmd.vAddr, va, "command address");
      if (cop == 3'h5 && csel == CSEL_INSN)
        check_val(64'({cacheCmd.useParityOverride, cacheCmd.parity}), 64'(9'h15a),
          "parity");
      tlbDone = 1'b1;
      tlbPaddr = PADDR;
      lineTag = tag;
      {tlbModified, lineValid, lineDirty, tlbRefill, tlbInvalid} = f;
      step(1);
      tlbDone = 1'b0;
      {tlbModified, lineValid, lineDirty, tlbRefill, tlbInvalid} = 5'h00;
      tlbPaddr = ~PADDR;
    end
    step(3);
    check_flags(exp, care, "cache outcome");
    if (exp[9]) check_val(wbAddr, {tag, va[11:4], 4'h0}, "writeback address");
  endtask : do_cache

  task automatic sc_cache();
    // Only listed operation and cache pairs on cached addresses are issued.
    do_cache(COP_HIT_INV, CSEL_DATA, 1, 0, TAG_HIT, 5'h08, 10'h010, 10'h3ff);
    do_cache(COP_HIT_INV, CSEL_DATA, 0, 0, TAG_HIT, 5'h08, 10'h100, 10'h3ff);
    do_cache(COP_HIT_WBINV, CSEL_DATA, 1, 1, TAG_HIT, 5'h0c, 10'h300, 10'h3ff);
    do_cache(COP_HIT_WBINV, CSEL_DATA, 0, 0, TAG_MISS, 5'h0c, 10'h000, 10'h3ff);
    do_cache(COP_HIT_WBINV, CSEL_DATA, 0, 0, TAG_HIT, 5'h04, 10'h000, 10'h3ff);
    do_cache(COP_IDX_INV, CSEL_DATA, 0, 0, TAG_MISS, 5'h1c, 10'h200, 10'h2ff);
    do_cache(COP_IDX_LDTAG, CSEL_INSN, 0, 0, TAG_MISS, 5'h18, 10'h000, 10'h0ff);
    do_cache(COP_HIT_INV, CSEL_DATA, 0, 0, TAG_HIT, 5'h0a, 10'h020, 10'h3ff);
    do_cache(COP_HIT_INV, CSEL_INSN, 0, 0, TAG_HIT, 5'h09, 10'h040, 10'h3ff);
    do_cache(3'h5, CSEL_INSN, 0, 0, TAG_HIT, 5'h08, 10'h000, 10'h0ff);
  endtask : sc_cache

  initial begin
    sys_rst = 1'b1;
    clockEnable = 1'b1;
    issue = '0;
    {tlbDone, tlbRefill, tlbInvalid, tlbModified, lineValid, lineDirty} = 6'h00;
    tlbPaddr = 64'h0;
    lineTag = '0;
    seen = '0;
    step(6);
    sys_rst = 1'b0;
    sc_negative();
    sc_unequal();
    sc_break();
    sc_cache();
    report_and_stop();
  end
endmodule : bbco_exec_tb_top
`default_nettype wire
